// file: design/wts_pkg.sv
// Package for the waveform trigger select block: register map, field layout,
// reset values, source codes and timing counts.
// Assumes a single 250 MHz system clock.
package wts_pkg;
   localparam int WTS_CLK_MHZ = 250;
   localparam logic [3:0] WTS_ADDR_CTRL = 4'h0;
   localparam logic [3:0] WTS_ADDR_BURST = 4'h1;
   localparam logic [3:0] WTS_ADDR_PERIOD = 4'h2;
   localparam logic [3:0] WTS_ADDR_CMD = 4'h3;
   localparam logic [3:0] WTS_ADDR_STATUS = 4'h4;
   // Control register fields.
   localparam int WTS_CTRL_SRC_LSB = 0;
   localparam int WTS_CTRL_LINE_LSB = 2;
   localparam int WTS_CTRL_POL_BIT = 5;
   localparam int WTS_CTRL_BGATE_BIT = 6;
   localparam int WTS_CTRL_KEY_BIT = 7;
   localparam int WTS_CTRL_BEN_BIT = 8;
   localparam int WTS_CTRL_SWEEP_BIT = 9;
   localparam int WTS_CTRL_DRV_BIT = 10;
   localparam int WTS_CTRL_DLINE_LSB = 11;
   // Command register bits; each write bit is a one-cycle action.
   localparam int WTS_CMD_TRG_BIT = 0;
   localparam int WTS_CMD_OUT_BIT = 1;
   localparam int WTS_CMD_APPLY_BIT = 2;
   localparam logic [31:0] WTS_CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] WTS_BURST_RESET = 16'h0001;
   localparam logic [31:0] WTS_PERIOD_RESET = 32'h0026_25a0;
   // Drive pulse on the backplane line, in nanoseconds.
   localparam int WTS_DRIVE_NS = 40;
   localparam int WTS_DRIVE_CYC = (WTS_DRIVE_NS * WTS_CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {
      WTS_SRC_IMM = 2'b00,
      WTS_SRC_EXT = 2'b01,
      WTS_SRC_LINE = 2'b10,
      WTS_SRC_BUS = 2'b11
   } wts_src_e;
   typedef enum logic [1:0] {
      WTS_ST_IDLE = 2'b00,
      WTS_ST_BURST = 2'b01,
      WTS_ST_SWEEP = 2'b10
   } wts_state_e;
endpackage

// file: design/wts_sync_edge.sv
// Two-flop synchroniser with edge detection on the synchronised level.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module wts_sync_edge #(
   parameter logic IDLE = 1'b0
) (
   input wire logic clk_sys, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic ce, // clock enable
   input wire logic din, // raw pin level
   output logic level, // synchronised level
   output logic rise, // one-cycle rising pulse
   output logic fall // one-cycle falling pulse
);
   logic meta;
   logic sync;
   logic prev;
   logic next_meta;
   logic next_sync;
   logic next_prev;
   always_comb begin
      next_meta = ce ? din : meta;
      next_sync = ce ? meta : sync;
      next_prev = ce ? sync : prev;
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         // Reset to the pin's idle level so that leaving reset makes no false edge.
         meta <= IDLE;
         sync <= IDLE;
         prev <= IDLE;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end
   assign level = sync;
   assign rise = ce & sync & ~prev;
   assign fall = ce & ~sync & prev;
endmodule
`default_nettype wire

// file: design/wts_top.sv
// Trigger selection and qualification for a waveform generator, with
// burst cycle counting, external gating and keying, and backplane drive.
// Assumes pins are asynchronous and registers are reached over a plain port.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module wts_top
   import wts_pkg::*;
#(
   parameter int LINES = 8,
   parameter int CNT_W = 16
) (
   input wire logic clk_sys, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic [3:0] addr, // register address
   input wire logic [31:0] wdata, // register write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, valid the cycle after rd
   input wire logic ext_in, // external trigger / gate / keying input
   input wire logic [LINES-1:0] line_in, // backplane trigger lines, input side
   output logic [LINES-1:0] line_out, // backplane line drive level (low = true)
   output logic [LINES-1:0] line_oe, // backplane line output enable
   input wire logic cycle_done, // one pulse per finished waveform cycle
   input wire logic sweep_done, // pulse when a sweep has finished
   output logic trig_pulse, // accepted trigger, one cycle
   output logic burst_active, // counted burst in progress
   output logic sweep_active, // sweep in progress
   output logic wave_enable, // waveform output enable
   output logic hop_select // high selects hop frequency
);
   localparam int LW = $clog2(LINES);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic ext_lvl, ext_rise, ext_fall;
   logic [LINES-1:0] ln_lvl, ln_rise, ln_fall;
   wts_sync_edge u_ext (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .din(ext_in),
      .level(ext_lvl),
      .rise(ext_rise),
      .fall(ext_fall)
   );
   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi++) begin : g_line
         // Backplane lines idle high on their pull-ups.
         wts_sync_edge #(.IDLE(1'b1)) u_ln (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ce(ce),
            .din(line_in[gi]),
            .level(ln_lvl[gi]),
            .rise(ln_rise[gi]),
            .fall(ln_fall[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [31:0] ctrl, next_ctrl;
   logic [CNT_W-1:0] burst_cycle_count, next_burst_cycle_count;
   logic [31:0] period, next_period;
   logic [31:0] next_rdata;
   logic cmd_trg, cmd_out;
   wts_src_e trigger_source_select;
   logic [LW-1:0] line_sel, drive_line;
   logic polarity_falling, burst_gate_source_select, keying_source_select;
   logic burst_enable, sweep_enable, trigger_line_drive_enable;

   assign trigger_source_select = wts_src_e'(ctrl[WTS_CTRL_SRC_LSB +: 2]);
   assign line_sel = ctrl[WTS_CTRL_LINE_LSB +: LW];
   assign polarity_falling = ctrl[WTS_CTRL_POL_BIT];
   assign burst_gate_source_select = ctrl[WTS_CTRL_BGATE_BIT];
   assign keying_source_select = ctrl[WTS_CTRL_KEY_BIT];
   assign burst_enable = ctrl[WTS_CTRL_BEN_BIT];
   assign sweep_enable = ctrl[WTS_CTRL_SWEEP_BIT];
   assign trigger_line_drive_enable = ctrl[WTS_CTRL_DRV_BIT];
   assign drive_line = ctrl[WTS_CTRL_DLINE_LSB +: LW];
   assign cmd_trg = ce & wr & (addr == WTS_ADDR_CMD) & wdata[WTS_CMD_TRG_BIT];
   assign cmd_out = ce & wr & (addr == WTS_ADDR_CMD) & wdata[WTS_CMD_OUT_BIT];

   wts_state_e state, next_state;
   logic [CNT_W-1:0] cyc_left, next_cyc_left;
   logic [31:0] tmr, next_tmr;
   logic [7:0] drv_cnt, next_drv_cnt;

   always_comb begin
      next_ctrl = ctrl;
      next_burst_cycle_count = burst_cycle_count;
      next_period = period;
      next_rdata = 32'h0000_0000;
      if (ce && wr) begin
         unique case (addr)
            WTS_ADDR_CTRL: next_ctrl = wdata;
            WTS_ADDR_BURST: next_burst_cycle_count = wdata[CNT_W-1:0];
            WTS_ADDR_PERIOD: next_period = wdata;
            WTS_ADDR_CMD: begin
               if (wdata[WTS_CMD_APPLY_BIT]) begin
                  // The combined configuration returns to the internal source.
                  next_ctrl[WTS_CTRL_SRC_LSB +: 2] = WTS_SRC_IMM;
               end
            end
            default: ;
         endcase
      end
      if (ce && rd) begin
         unique case (addr)
            WTS_ADDR_CTRL: next_rdata = ctrl;
            WTS_ADDR_BURST: next_rdata = {{(32-CNT_W){1'b0}}, burst_cycle_count};
            WTS_ADDR_PERIOD: next_rdata = period;
            WTS_ADDR_STATUS: next_rdata = {25'h0, hop_select, wave_enable,
               sweep_active, burst_active, ext_lvl, state};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger selection and qualification.
   logic sel_line_lvl, sel_line_rise, sel_line_fall;
   logic timer_fire, edge_fire, next_trig;
   assign sel_line_lvl = ln_lvl[line_sel];
   assign sel_line_rise = ln_rise[line_sel];
   assign sel_line_fall = ln_fall[line_sel];
   assign timer_fire = (tmr == 32'h0000_0000);

   always_comb begin
      edge_fire = 1'b0;
      unique case (trigger_source_select)
         WTS_SRC_IMM: edge_fire = ce & timer_fire;
         // External input: rising when positive, falling when negative.
         WTS_SRC_EXT: edge_fire = polarity_falling ? ext_fall : ext_rise;
         // Backplane lines have inverted sense: ground true under positive.
         WTS_SRC_LINE: edge_fire = polarity_falling ? sel_line_rise : sel_line_fall;
         WTS_SRC_BUS: edge_fire = cmd_trg;
      endcase
   end

   logic gated_mode, keyed_mode, gate_lvl;
   assign gated_mode = burst_enable & burst_gate_source_select;
   assign keyed_mode = keying_source_select;
   // Gate level comes from the line when one is selected, else the front input.
   assign gate_lvl = (trigger_source_select == WTS_SRC_LINE) ? ~sel_line_lvl : ext_lvl;
   // Gated burst and keying take no triggers; polarity plays no part there.
   assign next_trig = edge_fire & (burst_enable | sweep_enable) & ~gated_mode
      & ~keyed_mode;

   always_comb begin
      next_tmr = tmr;
      if (ce) begin
         if (trigger_source_select != WTS_SRC_IMM || timer_fire) begin
            next_tmr = period;
         end else begin
            next_tmr = tmr - 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst and sweep sequencing. A trigger while busy is dropped so that
   // every edge maps to at most one run and runs never overlap.
   always_comb begin
      next_state = state;
      next_cyc_left = cyc_left;
      if (ce) begin
         unique case (state)
            WTS_ST_IDLE: begin
               if (next_trig && burst_enable) begin
                  next_state = WTS_ST_BURST;
                  next_cyc_left = burst_cycle_count;
               end else if (next_trig && sweep_enable) begin
                  next_state = WTS_ST_SWEEP;
               end
            end
            WTS_ST_BURST: begin
               if (cycle_done) begin
                  next_cyc_left = cyc_left - {{(CNT_W-1){1'b0}}, 1'b1};
                  if (cyc_left <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                     next_state = WTS_ST_IDLE;
                  end
               end
            end
            WTS_ST_SWEEP: begin
               if (sweep_done) begin
                  next_state = WTS_ST_IDLE;
               end
            end
            default: next_state = WTS_ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and backplane drive.
   logic next_trig_pulse, next_burst_active, next_sweep_active;
   logic next_wave_enable, next_hop_select;
   logic [LINES-1:0] next_line_out, next_line_oe;
   always_comb begin
      next_drv_cnt = drv_cnt;
      if (ce) begin
         if (cmd_out && trigger_line_drive_enable) begin
            next_drv_cnt = 8'(WTS_DRIVE_CYC);
         end else if (drv_cnt != 8'h00) begin
            next_drv_cnt = drv_cnt - 8'h01;
         end
      end
      next_trig_pulse = ce ? next_trig : trig_pulse;
      next_burst_active = next_state == WTS_ST_BURST;
      next_sweep_active = next_state == WTS_ST_SWEEP;
      if (gated_mode) begin
         next_wave_enable = gate_lvl;
      end else if (burst_enable) begin
         next_wave_enable = next_state == WTS_ST_BURST;
      end else begin
         next_wave_enable = 1'b1;
      end
      next_hop_select = keyed_mode & gate_lvl;
      next_line_oe = '0;
      next_line_out = '1;
      if (next_drv_cnt != 8'h00) begin
         // Lines are ground true: drive low to assert.
         next_line_oe[drive_line] = 1'b1;
         next_line_out[drive_line] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl <= WTS_CTRL_RESET;
         burst_cycle_count <= WTS_BURST_RESET[CNT_W-1:0];
         period <= WTS_PERIOD_RESET;
         rdata <= 32'h0000_0000;
         state <= WTS_ST_IDLE;
         cyc_left <= '0;
         tmr <= WTS_PERIOD_RESET;
         drv_cnt <= 8'h00;
         trig_pulse <= 1'b0;
         burst_active <= 1'b0;
         sweep_active <= 1'b0;
         wave_enable <= 1'b1;
         hop_select <= 1'b0;
         line_out <= '1;
         line_oe <= '0;
      end else if (ce) begin
         ctrl <= next_ctrl;
         burst_cycle_count <= next_burst_cycle_count;
         period <= next_period;
         rdata <= next_rdata;
         state <= next_state;
         cyc_left <= next_cyc_left;
         tmr <= next_tmr;
         drv_cnt <= next_drv_cnt;
         trig_pulse <= next_trig_pulse;
         burst_active <= next_burst_active;
         sweep_active <= next_sweep_active;
         wave_enable <= next_wave_enable;
         hop_select <= next_hop_select;
         line_out <= next_line_out;
         line_oe <= next_line_oe;
      end
   end
endmodule
`default_nettype wire

// file: sim/wts_far.sv
// Far-side model: waveform engine pulses and the open-collector backplane lines.
// Assumes the bench drives the other units' line levels on line_tb.
`timescale 1ns/1ns
`default_nettype none
module wts_far (
   input wire logic clk_sys, // system clock
   input wire logic burst_active, // burst running
   input wire logic sweep_active, // sweep running
   input wire logic [7:0] line_out, // drive level
   input wire logic [7:0] line_oe, // drive enable
   input wire logic [7:0] line_tb, // levels from other units
   output var logic cycle_done, // cycle end pulse
   output var logic sweep_done, // sweep end pulse
   output logic [7:0] line_in // resolved lines
);
   int n = 0;
   // Lines have pull-ups and ground-true drivers, so any low drive wins.
   assign line_in = line_tb & ~(line_oe & ~line_out);
   always @(posedge clk_sys) begin
      n <= (burst_active || sweep_active) ? n + 1 : 0;
      cycle_done <= burst_active && n % 4 == 3;
      sweep_done <= sweep_active && n == 30;
   end
endmodule
`default_nettype wire

// file: sim/wts_checker_asserts.sv
// Port-level checker for the trigger select block.
// Assumes it sees only the top module ports; ce is high whenever bus or pins move.
`timescale 1ns/1ns
`default_nettype none
module wts_checker
   import wts_pkg::*;
#(
   parameter int LINES = 8
) (
   input wire logic clk_sys, // clock
   input wire logic nrst, // reset
   input wire logic [3:0] addr, // address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic ext_in, // pin
   input wire logic [LINES-1:0] line_in, // lines
   input wire logic [LINES-1:0] line_out, // drive level
   input wire logic [LINES-1:0] line_oe, // drive enable
   input wire logic trig_pulse, // trigger
   input wire logic burst_active, // burst
   input wire logic wave_enable, // output on
   input wire logic hop_select // hop
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [13:0] ctl;
   logic [13:0] next_ctl;
   logic edge_ok;
   logic cmd;
   logic [2:0] dl;
   //////////////////////////////////////////////////////////////
   // Shadow of the control register, so each property knows the mode.
   always_comb begin
      next_ctl = ctl;
      if (wr && addr == WTS_ADDR_CTRL) begin
         next_ctl = wdata[13:0];
      end else if (wr && addr == WTS_ADDR_CMD && wdata[WTS_CMD_APPLY_BIT]) begin
         next_ctl[1:0] = 2'h0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctl <= 14'h0;
      end else begin
         ctl <= next_ctl;
      end
   end
   assign edge_ok = (ctl[8] || ctl[9]) && !ctl[6] && !ctl[7];
   assign cmd = wr && addr == WTS_ADDR_CMD;
   assign dl = ctl[13:11];
   sequence s_drv;
      (line_oe[dl] && !line_out[dl])[*8];
   endsequence
   property p_reset;
      $rose(nrst) |-> line_oe == '0 && !trig_pulse && !burst_active && wave_enable && !hop_select;
   endproperty
   property p_ext_rise;
      edge_ok && ctl[1:0] == WTS_SRC_EXT && !ctl[5] && $rose(ext_in) |-> ##[1:5] trig_pulse;
   endproperty
   property p_ext_fall;
      edge_ok && ctl[1:0] == WTS_SRC_EXT && ctl[5] && $fell(ext_in) |-> ##[1:5] trig_pulse;
   endproperty
   property p_line_fall;
      edge_ok && ctl[1:0] == WTS_SRC_LINE && !ctl[5] && $fell(line_in[ctl[4:2]])
         |-> ##[1:5] trig_pulse;
   endproperty
   property p_bus;
      edge_ok && ctl[1:0] == WTS_SRC_BUS && cmd && wdata[0] |=> trig_pulse;
   endproperty
   property p_drive;
      ctl[10] && cmd && wdata[1] |=> s_drv ##1 line_oe[dl] ##1 line_oe[dl] ##1 !line_oe[dl];
   endproperty
   property p_gate;
      ctl[8] && ctl[6] && ctl[1:0] != WTS_SRC_LINE && $rose(ext_in) |-> ##[1:5] wave_enable;
   endproperty
   property p_hop;
      ctl[7] && ctl[1:0] != WTS_SRC_LINE && $fell(ext_in) |-> ##[1:5] !hop_select;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   a_ext_rise: assert property (p_ext_rise) else $error("no rise trigger");
   a_ext_fall: assert property (p_ext_fall) else $error("no fall trigger");
   a_line_fall: assert property (p_line_fall) else $error("no line trigger");
   a_bus: assert property (p_bus) else $error("no bus trigger");
   a_drive: assert property (p_drive) else $error("line drive wrong");
   a_gate: assert property (p_gate) else $error("gate not open");
   a_hop: assert property (p_hop) else $error("hop not cleared");
endmodule
bind wts_top wts_checker #(.LINES(LINES)) u_chk (.clk_sys, .nrst, .addr, .wdata, .wr, .ext_in,
   .line_in, .line_out, .line_oe, .trig_pulse, .burst_active, .wave_enable, .hop_select);
`default_nettype wire

// file: sim/test_waveform_trigger_select.sv
// Self-checking bench for the trigger select block.
// Assumes the far-side model resolves the backplane lines.
`timescale 1ns/1ns
`default_nettype none
module test_waveform_trigger_select;
   import wts_pkg::*;
   logic clk_sys = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ext_in = 1'b0, ce = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [7:0] line_in, line_out, line_oe, line_tb = 8'hff;
   logic cycle_done, sweep_done, trig_pulse, burst_active, sweep_active, wave_enable, hop_select;
   int errors = 0, checks = 0, ntrig = 0, ncyc = 0;
   always #2 clk_sys = ~clk_sys;
   wts_top uut (.clk_sys, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .ext_in, .line_in,
      .line_out, .line_oe, .cycle_done, .sweep_done, .trig_pulse, .burst_active, .sweep_active,
      .wave_enable, .hop_select);
   wts_far far (.clk_sys, .burst_active, .sweep_active, .line_out, .line_oe, .line_tb,
      .cycle_done, .sweep_done, .line_in);
   always @(posedge clk_sys) begin
      ntrig <= ntrig + (trig_pulse === 1'b1);
      ncyc <= ncyc + (cycle_done && burst_active === 1'b1);
   end
   //////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic put(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [3:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 cmp(nm, e, rdata);
   endtask
   task automatic reset;
      @(posedge clk_sys);
      nrst <= 1'b0;
      cyc(4);
      nrst <= 1'b1;
   endtask
   task automatic t_regs;
      get(WTS_ADDR_CTRL, WTS_CTRL_RESET, "ctrl");
      get(WTS_ADDR_STATUS, 32'h20, "status");
      get(WTS_ADDR_BURST, 32'h1, "count");
      get(WTS_ADDR_PERIOD, WTS_PERIOD_RESET, "period");
      get(4'h5, 32'h0, "unmapped");
      $display("registers done");
   endtask
   task automatic wtrig(output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (trig_pulse !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic t_timer;
      int n;
      int a;
      put(WTS_ADDR_PERIOD, 32'h14);
      // Leave the internal source for two cycles so the timer reloads the new period.
      put(WTS_ADDR_CTRL, 32'h3);
      put(WTS_ADDR_CTRL, 32'h100);
      wtrig(n);
      wtrig(n);
      cmp("period", 32'h15, n);
      // With the clock enable low the timer must not advance.
      @(posedge clk_sys);
      ce <= 1'b0;
      @(negedge clk_sys);
      a = ntrig;
      cyc(30);
      @(negedge clk_sys);
      cmp("frozen", 0, ntrig - a);
      @(posedge clk_sys);
      ce <= 1'b1;
      put(WTS_ADDR_CTRL, 32'h0);
      cyc(20);
      $display("timer done");
   endtask
   // Phase one is the active edge for positive polarity on either source.
   task automatic t_edges;
      int a, c;
      put(WTS_ADDR_BURST, 32'h3);
      for (int s = 0; s < 2; s++) begin
         for (int p = 0; p < 2; p++) begin
            put(WTS_ADDR_CTRL, 32'h100 | (s ? 32'h16 : 32'h1) | (p << 5));
            a = ntrig;
            c = ncyc;
            if (s) line_tb[5] <= 1'b0;
            else ext_in <= 1'b1;
            cyc(520);
            cmp("first edge", 1 - p, ntrig - a);
            if (s) line_tb[5] <= 1'b1;
            else ext_in <= 1'b0;
            cyc(520);
            cmp("triggers", 1, ntrig - a);
            cmp("cycles", 3, ncyc - c);
         end
      end
      $display("edges done");
   endtask
   task automatic t_gate;
      int a;
      for (int m = 0; m < 2; m++) begin
         put(WTS_ADDR_CTRL, m ? 32'ha1 : 32'h161);
         a = ntrig;
         ext_in <= 1'b1;
         cyc(8);
         @(negedge clk_sys);
         cmp("level high", 1, m ? hop_select : wave_enable);
         @(posedge clk_sys);
         ext_in <= 1'b0;
         cyc(8);
         @(negedge clk_sys);
         cmp("level low", 0, m ? hop_select : wave_enable);
         cmp("gated triggers", 0, ntrig - a);
      end
      $display("gating done");
   endtask
   task automatic t_drive;
      put(WTS_ADDR_CTRL, 32'h1c00);
      put(WTS_ADDR_CMD, 32'h2);
      @(negedge clk_sys);
      cmp("drive oe", 8'h08, line_oe);
      cmp("drive line", 8'hf7, line_in);
      cyc(12);
      @(negedge clk_sys);
      cmp("released", 8'h00, line_oe);
      $display("drive done");
   endtask
   task automatic t_bus;
      int a;
      put(WTS_ADDR_CTRL, 32'h203);
      a = ntrig;
      ext_in <= 1'b1;
      cyc(20);
      ext_in <= 1'b0;
      cyc(10);
      cmp("ext ignored", 0, ntrig - a);
      put(WTS_ADDR_CMD, 32'h1);
      @(negedge clk_sys);
      cmp("sweep", 1, sweep_active);
      cyc(60);
      cmp("bus triggers", 1, ntrig - a);
      put(WTS_ADDR_CMD, 32'h4);
      get(WTS_ADDR_CTRL, 32'h200, "applied");
      $display("bus done");
   endtask
   initial begin
      reset();
      t_regs();
      t_timer();
      t_edges();
      t_gate();
      t_drive();
      t_bus();
      reset();
      t_regs();
      give_verdict();
   end
endmodule
`default_nettype wire
